// file: dv/mpba_monitor.sv
// Checker on the arbitration pins between the processor and host ends
`timescale 1ns/100ps
module mpba_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Request lines and identity
  input wire logic [7:0] br_dev_oe_n,
  input wire logic [7:0] bus_request_lines_n,
  input wire logic [2:0] processor_identity,
  // Indicators
  input wire logic master_indicator,
  input wire logic lock_indicator_oe_n,
  // Host handshake
  input wire logic host_request_n,
  input wire logic host_back_off_n,
  input wire logic host_grant_out_n,
  input wire logic host_grant_oe_n,
  // Priority lines and bus pins
  input wire logic core_priority_out_n,
  input wire logic dma_priority_out_n,
  input wire logic bus_drive_oe_n,
  input wire logic sdram_self_refresh
);
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic grant_drv;
  assign grant_drv = !host_grant_oe_n && !host_grant_out_n;

  own_line_only_a: assert property ((br_dev_oe_n | (8'h01 << processor_identity)) == 8'hFF)
    else $error("request line other than own driven");
  bus_needs_line_a: assert property (!bus_drive_oe_n |-> !bus_request_lines_n[processor_identity])
    else $error("bus driven without own request");
  bus_master_a: assert property (!bus_drive_oe_n |-> master_indicator)
    else $error("bus driven without master indicator");
  lock_by_owner_a: assert property (!lock_indicator_oe_n |-> master_indicator)
    else $error("lock indicator driven by non-owner");
  backoff_release_a: assert property (!host_back_off_n && !bus_drive_oe_n |=> bus_drive_oe_n)
    else $error("bus kept after back-off");
  grant_floats_a: assert property (grant_drv |-> bus_drive_oe_n && sdram_self_refresh)
    else $error("grant while bus driven or no self-refresh");
  grant_kept_a: assert property (grant_drv && !host_request_n |=> grant_drv)
    else $error("grant dropped while host requests");
  grant_drop_a: assert property (grant_drv && host_request_n |=> !grant_drv)
    else $error("grant kept after request removed");
  grant_by_master_a: assert property (!host_grant_oe_n |-> master_indicator)
    else $error("grant driven by a slave");
  open_drain_a: assert property (core_priority_out_n == 1'b0 && dma_priority_out_n == 1'b0)
    else $error("priority line driven high");
endmodule

// file: dv/multiproc_bus_arbitration_bench.sv
// Bench joining a processor end and a host end
`timescale 1ns/100ps
module multiproc_bus_arbitration_bench;
  import mpba_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic host_resetn = 1'b0;
  logic core_req, dma_req, dma_high, lock_req, xact_busy, host_want, backoff_cmd;
  logic bus_granted, dma_suspended, abort_xact, host_holds_bus, strap_master, strap_lock, host_owns;
  int fail_count = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  mpba_if mpba_if_inst ();
  mpba_proc mpba_proc_inst (.clk(clk), .resetn(resetn), .link(mpba_if_inst.proc), .core_req(core_req),
    .dma_req(dma_req), .dma_high(dma_high), .lock_req(lock_req), .xact_busy(xact_busy),
    .bus_granted(bus_granted), .dma_suspended(dma_suspended), .abort_xact(abort_xact),
    .host_holds_bus(host_holds_bus), .strap_master(strap_master), .strap_lock(strap_lock));
  mpba_host mpba_host_inst (.clk(clk), .resetn(host_resetn), .link(mpba_if_inst.host), .host_want(host_want),
    .backoff_cmd(backoff_cmd), .cfg_identity(3'h2), .present_mask(8'h27), .host_owns(host_owns));
  mpba_monitor mpba_monitor_inst (.clk(clk), .resetn(resetn), .br_dev_oe_n(mpba_if_inst.br_dev_oe_n),
    .bus_request_lines_n(mpba_if_inst.bus_request_lines_n), .processor_identity(mpba_if_inst.processor_identity),
    .master_indicator(mpba_if_inst.master_indicator), .lock_indicator_oe_n(mpba_if_inst.lock_indicator_oe_n),
    .host_request_n(mpba_if_inst.host_request_n), .host_back_off_n(mpba_if_inst.host_back_off_n),
    .host_grant_out_n(mpba_if_inst.host_grant_out_n), .host_grant_oe_n(mpba_if_inst.host_grant_oe_n),
    .core_priority_out_n(mpba_if_inst.core_priority_out_n), .dma_priority_out_n(mpba_if_inst.dma_priority_out_n),
    .bus_drive_oe_n(mpba_if_inst.bus_drive_oe_n), .sdram_self_refresh(mpba_if_inst.sdram_self_refresh));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic wait_granted();
    for (int i = 0; i < 30 && bus_granted !== 1'b1; i++) step(1);
  endtask

  task automatic conclude();
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #50000;
    fail_count++;
    conclude();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    {core_req, dma_req, dma_high, lock_req, xact_busy, host_want, backoff_cmd} = 7'h00;
    mpba_if_inst.br_ext_n = 8'hFF;
    mpba_if_inst.master_strap_ext = 1'b1;
    mpba_if_inst.lock_strap_ext = 1'b1;
    mpba_if_inst.host_grant_ext_n = 1'b1;
    mpba_if_inst.core_priority_ext_n = 1'b1;
    mpba_if_inst.dma_priority_ext_n = 1'b1;
    step(16);
    host_resetn = 1'b1;
    step(2);
    resetn = 1'b1;
    step(2);
    chk("absent_drive", 8'h27, mpba_if_inst.br_host_oe_n);
    chk("lines_idle", 8'hFF, mpba_if_inst.bus_request_lines_n);
    chk("identity", 8'h02, mpba_if_inst.processor_identity);
    chk("strap_master", 8'h01, strap_master);
    chk("strap_lock", 8'h01, strap_lock);
    core_req = 1'b1;
    step(1);
    chk("own_line", 8'hFB, mpba_if_inst.bus_request_lines_n);
    step(1);
    chk("core_pri", 8'h00, mpba_if_inst.core_priority_line_n);
    wait_granted();
    chk("granted", 8'h01, bus_granted);
    chk("master", 8'h01, mpba_if_inst.master_indicator);
    lock_req = 1'b1;
    step(2);
    chk("lock", 8'h01, mpba_if_inst.lock_indicator);
    lock_req = 1'b0;
    // Rotation toward another requester
    mpba_if_inst.br_ext_n[5] = 1'b0;
    step(3);
    chk("kept", 8'h01, bus_granted);
    core_req = 1'b0;
    step(4);
    chk("lost_master", 8'h00, mpba_if_inst.master_indicator);
    chk("watch_lines", 8'hDF, mpba_if_inst.bus_request_lines_n);
    core_req = 1'b1;
    step(4);
    chk("waits_other", 8'h00, bus_granted);
    mpba_if_inst.br_ext_n[5] = 1'b1;
    wait_granted();
    chk("regained", 8'h01, bus_granted);
    // Priority lines against background DMA
    dma_req = 1'b1;
    core_req = 1'b0;
    step(2);
    mpba_if_inst.core_priority_ext_n = 1'b0;
    step(1);
    chk("core_suspend", 8'h01, dma_suspended);
    mpba_if_inst.core_priority_ext_n = 1'b1;
    wait_granted();
    mpba_if_inst.dma_priority_ext_n = 1'b0;
    step(1);
    chk("dma_suspend", 8'h01, dma_suspended);
    mpba_if_inst.dma_priority_ext_n = 1'b1;
    dma_high = 1'b1;
    wait_granted();
    chk("dma_pri", 8'h00, mpba_if_inst.dma_priority_line_n);
    mpba_if_inst.dma_priority_ext_n = 1'b0;
    step(3);
    chk("high_kept", 8'h00, dma_suspended);
    mpba_if_inst.dma_priority_ext_n = 1'b1;
    {dma_req, dma_high} = 2'h0;
    // Host takes the bus after the transaction ends
    core_req = 1'b1;
    xact_busy = 1'b1;
    wait_granted();
    host_want = 1'b1;
    step(4);
    chk("grant_waits", 8'h01, mpba_if_inst.host_grant_n);
    xact_busy = 1'b0;
    for (int i = 0; i < 10 && mpba_if_inst.host_grant_n !== 1'b0; i++) step(1);
    chk("grant", 8'h00, mpba_if_inst.host_grant_n);
    chk("refresh", 8'h01, mpba_if_inst.sdram_self_refresh);
    chk("floated", 8'h01, mpba_if_inst.bus_drive_oe_n);
    step(5);
    chk("grant_held", 8'h00, mpba_if_inst.host_grant_n);
    chk("host_owns", 8'h01, host_owns);
    host_want = 1'b0;
    step(4);
    chk("grant_off", 8'h01, mpba_if_inst.host_grant_n);
    // Back-off in mid-transaction
    wait_granted();
    xact_busy = 1'b1;
    backoff_cmd = 1'b1;
    for (int i = 0; i < 6 && abort_xact !== 1'b1; i++) step(1);
    chk("abort", 8'h01, abort_xact);
    chk("backoff_float", 8'h01, mpba_if_inst.bus_drive_oe_n);
    {backoff_cmd, xact_busy, core_req} = 3'h0;
    // Another master grants the host
    mpba_if_inst.br_ext_n[0] = 1'b0;
    step(4);
    mpba_if_inst.host_grant_ext_n = 1'b0;
    step(3);
    chk("slave_grant_oe", 8'h01, mpba_if_inst.host_grant_oe_n);
    chk("holds_bus", 8'h01, host_holds_bus);
    core_req = 1'b1;
    step(3);
    chk("no_req", 8'hFE, mpba_if_inst.bus_request_lines_n);
    mpba_if_inst.host_grant_ext_n = 1'b1;
    mpba_if_inst.br_ext_n[0] = 1'b1;
    wait_granted();
    chk("final", 8'h01, bus_granted);
    conclude();
  end
endmodule

// file: hdl/mpba_host.sv
// Host end: host request and grant, back-off, identity and absent lines
`timescale 1ns/100ps
module mpba_host (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Arbitration pins
  mpba_if.host link,
  // User side
  input wire logic host_want,
  input wire logic backoff_cmd,
  input wire logic [mpba_pkg::MPBA_ID_W-1:0] cfg_identity,
  input wire logic [mpba_pkg::MPBA_NUM_PROC-1:0] present_mask,
  output logic host_owns
);
  import mpba_pkg::*;

  logic run;
  logic [MPBA_ID_W-1:0] identity;
  logic [7:0] absent_oe_n;
  logic back_off_n;
  logic request_n;
  mpba_host_state_t state;
  mpba_host_state_t next_state;
  logic grant_seen;

  assign grant_seen = !link.host_grant_n;
  assign link.processor_identity = identity;
  assign link.br_host_out_n = MPBA_LINES_IDLE;
  assign link.br_host_oe_n = absent_oe_n;
  assign link.host_back_off_n = back_off_n;
  assign link.host_request_n = request_n;

  // ************************************************************
  // Straps loaded only in the first cycle after reset release
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run <= 1'b0;
      identity <= MPBA_RST_ID;
      absent_oe_n <= MPBA_LINES_IDLE;
    end else begin
      run <= 1'b1;
      if (!run) begin
        identity <= cfg_identity; // RULE3
        absent_oe_n <= present_mask; // RULE4
      end
    end
  end

  // ************************************************************
  // Request and grant handshake
  // ************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      MPBA_H_IDLE: if (run && host_want) next_state = MPBA_H_REQ;
      MPBA_H_REQ: if (grant_seen) next_state = MPBA_H_OWN; // RULE8
      MPBA_H_OWN: if (!host_want) next_state = MPBA_H_DROP;
      MPBA_H_DROP: if (!grant_seen) next_state = MPBA_H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= MPBA_H_IDLE;
      request_n <= MPBA_LOW_IDLE;
      host_owns <= 1'b0;
      back_off_n <= MPBA_LOW_IDLE;
    end else begin
      state <= next_state;
      request_n <= !(next_state == MPBA_H_REQ || next_state == MPBA_H_OWN); // RULE8
      host_owns <= next_state == MPBA_H_OWN;
      back_off_n <= !backoff_cmd; // RULE7
    end
  end

endmodule

// file: hdl/mpba_if.sv
// Arbitration pins shared by one processor and the host side
`timescale 1ns/100ps
interface mpba_if;
  import mpba_pkg::*;

  // ************************************************************
  // Request lines, one per processor, active low
  // ************************************************************
  logic [7:0] br_dev_out_n;
  logic [7:0] br_dev_oe_n;
  logic [7:0] br_host_out_n;
  logic [7:0] br_host_oe_n;
  logic [7:0] br_ext_n;
  logic [7:0] bus_request_lines_n;
  logic [2:0] processor_identity;

  // ************************************************************
  // Indicators, also straps during reset
  // ************************************************************
  logic master_indicator_out;
  logic master_indicator_oe_n;
  logic master_strap_ext;
  logic master_indicator;
  logic lock_indicator_out;
  logic lock_indicator_oe_n;
  logic lock_strap_ext;
  logic lock_indicator;

  // ************************************************************
  // Host handshake
  // ************************************************************
  logic host_request_n;
  logic host_back_off_n;
  logic host_grant_out_n;
  logic host_grant_oe_n;
  logic host_grant_ext_n;
  logic host_grant_n;

  // ************************************************************
  // Shared open-drain priority lines
  // ************************************************************
  logic core_priority_out_n;
  logic core_priority_oe_n;
  logic core_priority_ext_n;
  logic core_priority_line_n;
  logic dma_priority_out_n;
  logic dma_priority_oe_n;
  logic dma_priority_ext_n;
  logic dma_priority_line_n;

  // ************************************************************
  // Own bus pins and SDRAM state
  // ************************************************************
  logic bus_drive_oe_n;
  logic sdram_self_refresh;

  // Wired levels; undriven request, grant and priority lines float high, undriven indicators read their strap
  assign bus_request_lines_n = (br_dev_oe_n | br_dev_out_n) & (br_host_oe_n | br_host_out_n) & br_ext_n;
  assign master_indicator = master_indicator_oe_n ? master_strap_ext : master_indicator_out;
  assign lock_indicator = lock_indicator_oe_n ? lock_strap_ext : lock_indicator_out;
  assign host_grant_n = (host_grant_oe_n | host_grant_out_n) & host_grant_ext_n;
  assign core_priority_line_n = (core_priority_oe_n | core_priority_out_n) & core_priority_ext_n;
  assign dma_priority_line_n = (dma_priority_oe_n | dma_priority_out_n) & dma_priority_ext_n;

  modport proc (
    output br_dev_out_n, br_dev_oe_n, master_indicator_out, master_indicator_oe_n,
    output lock_indicator_out, lock_indicator_oe_n, host_grant_out_n, host_grant_oe_n,
    output core_priority_out_n, core_priority_oe_n, dma_priority_out_n, dma_priority_oe_n,
    output bus_drive_oe_n, sdram_self_refresh,
    input bus_request_lines_n, processor_identity, master_indicator, lock_indicator,
    input host_request_n, host_back_off_n, host_grant_n, core_priority_line_n, dma_priority_line_n
  );

  modport host (
    output br_host_out_n, br_host_oe_n, processor_identity, host_request_n, host_back_off_n,
    input bus_request_lines_n, host_grant_n
  );

endinterface

// file: hdl/mpba_pkg.sv
// Shared constants and types for the multiprocessor bus arbitration ends
package mpba_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int MPBA_NUM_PROC = 8;
  localparam int MPBA_ID_W = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [2:0] MPBA_RST_ID = 3'h0;
  localparam logic [2:0] MPBA_RST_OWNER = 3'h0;
  localparam logic [7:0] MPBA_LINES_IDLE = 8'hFF;
  localparam logic MPBA_LOW_IDLE = 1'h1;
  localparam logic MPBA_HIGH_IDLE = 1'h0;

  // ************************************************************
  // State machines
  // ************************************************************
  typedef enum logic [2:0] {
    MPBA_IDLE = 3'h0,
    MPBA_REQ = 3'h1,
    MPBA_OWN = 3'h3,
    MPBA_HOLD = 3'h2,
    MPBA_BACKOFF = 3'h6
  } mpba_proc_state_t;

  typedef enum logic [1:0] {
    MPBA_H_IDLE = 2'h0,
    MPBA_H_REQ = 2'h1,
    MPBA_H_OWN = 2'h3,
    MPBA_H_DROP = 2'h2
  } mpba_host_state_t;

endpackage

// file: hdl/mpba_proc.sv
// Processor end: bus arbitration among processors and toward the host
// Operation
// RULE1: Drive own request line, watch all others
// RULE2: Identity selects line and arbitration order
// RULE3: Identity held constant except during reset
// RULE4: Absent processors' request lines held high
// RULE5: Current owner drives master indicator; reset strap
// RULE6: Owner drives lock indicator; reset strap
// RULE7: Back-off forces release without finishing transaction
// RULE8: Host requests, then waits for grant
// RULE9: Master finishes transaction, then grants host
// RULE10: On grant, float bus, SDRAM self-refresh
// RULE11: Grant held until host request removed
// RULE12: Only master drives grant; slaves monitor it
// RULE13: Core priority asserted during core external access
// RULE14: Slave core priority suspends master background DMA
// RULE15: DMA priority asserted for high-priority DMA
// RULE16: Slave high DMA preempts master normal DMA
// RULE17: Priority lines open-drain, wired to all
// RULE18: Same deterministic rotation picks one master
`timescale 1ns/100ps
module mpba_proc (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Arbitration pins
  mpba_if.proc link,
  // Requests from core and DMA
  input wire logic core_req,
  input wire logic dma_req,
  input wire logic dma_high,
  input wire logic lock_req,
  input wire logic xact_busy,
  // Status to core and DMA
  output logic bus_granted,
  output logic dma_suspended,
  output logic abort_xact,
  output logic host_holds_bus,
  // Straps caught at reset release
  output logic strap_master,
  output logic strap_lock
);
  import mpba_pkg::*;

  logic run;
  logic [MPBA_ID_W-1:0] id;
  logic [MPBA_NUM_PROC-1:0] req;
  logic [MPBA_ID_W-1:0] owner;
  logic [MPBA_ID_W-1:0] next_owner;
  mpba_proc_state_t state;
  mpba_proc_state_t next_state;
  logic is_master;
  logic host_req;
  logic back_off;
  logic grant_seen;
  logic core_prio_other;
  logic dma_prio_other;
  logic suspend_dma;
  logic want;
  logic keep_own;
  logic cpa_drive;
  logic dpa_drive;
  logic [7:0] br_oe_n;
  logic [7:0] br_out_n;
  logic master_out;
  logic master_oe_n;
  logic lock_out;
  logic lock_oe_n;
  logic grant_out_n;
  logic grant_oe_n;
  logic bus_oe_n;
  logic self_refresh;

  assign req = ~link.bus_request_lines_n; // RULE1
  assign host_req = !link.host_request_n;
  assign back_off = !link.host_back_off_n;
  assign grant_seen = !link.host_grant_n; // RULE12
  assign is_master = owner == id;

  // Priority lines seen low while this end is not pulling them
  assign core_prio_other = !link.core_priority_line_n && !cpa_drive;
  assign dma_prio_other = !link.dma_priority_line_n && !dpa_drive;

  // ************************************************************
  // Pin drivers
  // ************************************************************
  assign link.br_dev_out_n = br_out_n;
  assign link.br_dev_oe_n = br_oe_n;
  assign link.master_indicator_out = master_out;
  assign link.master_indicator_oe_n = master_oe_n;
  assign link.lock_indicator_out = lock_out;
  assign link.lock_indicator_oe_n = lock_oe_n;
  assign link.host_grant_out_n = grant_out_n;
  assign link.host_grant_oe_n = grant_oe_n;
  assign link.core_priority_out_n = 1'b0; // RULE17
  assign link.core_priority_oe_n = !cpa_drive; // RULE17
  assign link.dma_priority_out_n = 1'b0; // RULE17
  assign link.dma_priority_oe_n = !dpa_drive; // RULE17
  assign link.bus_drive_oe_n = bus_oe_n;
  assign link.sdram_self_refresh = self_refresh;

  // ************************************************************
  // Identity and straps, caught in the first cycle after reset
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run <= 1'b0;
      id <= MPBA_RST_ID;
      strap_master <= 1'b0;
      strap_lock <= 1'b0;
    end else begin
      run <= 1'b1;
      if (!run) begin
        id <= link.processor_identity; // RULE2
        strap_master <= link.master_indicator; // RULE5
        strap_lock <= link.lock_indicator; // RULE6
      end
    end
  end

  // ************************************************************
  // Ownership: rotate from current owner once its line drops
  // ************************************************************
  function automatic logic [MPBA_ID_W-1:0] mpba_pick(input logic [MPBA_NUM_PROC-1:0] r,
                                                     input logic [MPBA_ID_W-1:0] last);
    logic [MPBA_ID_W-1:0] res;
    logic [MPBA_ID_W-1:0] idx;
    res = last;
    for (int k = MPBA_NUM_PROC; k >= 1; k--) begin
      idx = last + MPBA_ID_W'(k);
      if (r[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction

  always_comb begin
    next_owner = owner;
    if (!req[owner] && |req) begin
      next_owner = mpba_pick(req, owner); // RULE18
    end
  end

  // Every agent runs the same update from the same lines
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      owner <= MPBA_RST_OWNER;
    end else if (run) begin
      owner <= next_owner; // RULE18
    end
  end

  // ************************************************************
  // Local demand and DMA suspension
  // ************************************************************
  always_comb begin
    want = core_req || dma_req;
    suspend_dma = !core_req && dma_req && (core_prio_other || (dma_prio_other && !dma_high)); // RULE14 RULE16
    keep_own = core_req || (dma_req && !suspend_dma);
  end

  // ************************************************************
  // Processor state machine
  // ************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      MPBA_IDLE: begin
        if (!run) begin
          next_state = MPBA_IDLE;
        end else if (is_master && host_req) begin
          next_state = MPBA_HOLD; // RULE9
        end else if (want && !grant_seen) begin
          next_state = MPBA_REQ; // RULE1
        end
      end
      MPBA_REQ: begin
        if (is_master && host_req) begin
          next_state = MPBA_HOLD; // RULE9
        end else if (!want) begin
          next_state = MPBA_IDLE;
        end else if (is_master && !grant_seen) begin
          next_state = MPBA_OWN;
        end
      end
      MPBA_OWN: begin
        if (back_off) begin
          next_state = MPBA_BACKOFF; // RULE7
        end else if (host_req && !xact_busy) begin
          next_state = MPBA_HOLD; // RULE9
        end else if (!xact_busy && !keep_own) begin
          next_state = MPBA_IDLE; // RULE14 RULE16
        end
      end
      MPBA_HOLD: begin
        if (!host_req) begin
          next_state = MPBA_IDLE; // RULE11
        end
      end
      MPBA_BACKOFF: begin
        if (!back_off) begin
          next_state = MPBA_IDLE; // RULE7
        end
      end
      default: next_state = MPBA_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= MPBA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Request line, indicators and grant
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      br_oe_n <= MPBA_LINES_IDLE;
      br_out_n <= MPBA_LINES_IDLE;
      master_out <= MPBA_HIGH_IDLE;
      master_oe_n <= 1'b1;
      lock_out <= MPBA_HIGH_IDLE;
      lock_oe_n <= 1'b1;
      grant_out_n <= MPBA_LOW_IDLE;
      grant_oe_n <= 1'b1;
    end else begin
      br_oe_n <= run ? ~(8'h01 << id) : MPBA_LINES_IDLE; // RULE1 RULE2
      br_out_n <= ~((next_state == MPBA_REQ || next_state == MPBA_OWN || next_state == MPBA_HOLD) ?
                    (8'h01 << id) : 8'h00); // RULE1
      // Identity not yet valid in the first cycle after reset
      master_out <= run && next_owner == id; // RULE5
      master_oe_n <= 1'b0;
      lock_out <= next_state == MPBA_OWN && lock_req; // RULE6
      lock_oe_n <= !run || next_owner != id; // RULE6
      grant_out_n <= next_state != MPBA_HOLD; // RULE9 RULE11
      grant_oe_n <= !run || next_owner != id; // RULE12
    end
  end

  // ************************************************************
  // Bus pins, SDRAM and priority lines
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_oe_n <= 1'b1;
      self_refresh <= 1'b0;
      cpa_drive <= 1'b0;
      dpa_drive <= 1'b0;
    end else begin
      bus_oe_n <= next_state != MPBA_OWN; // RULE10 RULE7
      self_refresh <= next_state == MPBA_HOLD; // RULE10
      cpa_drive <= run && core_req; // RULE13
      dpa_drive <= run && dma_req && dma_high; // RULE15
    end
  end

  // ************************************************************
  // User status
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_granted <= 1'b0;
      dma_suspended <= 1'b0;
      abort_xact <= 1'b0;
      host_holds_bus <= 1'b0;
    end else begin
      bus_granted <= next_state == MPBA_OWN;
      dma_suspended <= state == MPBA_OWN && suspend_dma; // RULE14 RULE16
      abort_xact <= state == MPBA_OWN && next_state == MPBA_BACKOFF; // RULE7
      host_holds_bus <= grant_seen; // RULE12
    end
  end

endmodule
